// ### design/rhw_wavegen.sv
// Behaviour
// [R1] cycle: low on, dead, high on, dead
// [R2] reset to idle; enable goes to wake-up
// [R3] wake timer expiry enters low-side on
// [R4] low-side on followed by dead time, unless a fault or disable sends it to idle
// [R5] low-to-high dead end enters high on
// [R6] high on, dead time, back to low
// [R7] on states have min and max timers, dead states a max and a min that a switch-node edge overrides; idle has a min, wake a fixed time
// [R8] current sign blanked 1us in dead time
// [R9] idle drives all gate and ramp outputs low; a fault flag can pulse in the first idle cycle
// [R10] idle entry reloads counters; startup on rise
// [R11] wake-up drives all outputs low
// [R12] low on: low gate and ramp
// [R13] low-to-high dead: gates off, high ramp
// [R14] high on: high gate and ramp
// [R15] high-to-low dead: gates off, low ramp
// [R16] zero-current flag follows detection when switching
// [R17] fast faults handled here, then reported
// [R18] idle exit: enable, feedback ok, min idle
// [R19] low on exit: min and (vcr low or max)
// [R20] high on exit: min and (vcr high or max)
// [R21] burst counter 15, stops switching at zero
// [R22] gates never both on
`timescale 1ns/1ps
`default_nettype none
`include "rhw_defs.svh"
module rhw_wavegen #(
	parameter logic [15:0] IDLE_MIN_CYC = 16'h0064,
	parameter logic [15:0] WAKE_CYC = 16'h00c8,
	parameter logic [15:0] DEAD_MIN_CYC = 16'h0004,
	parameter logic [15:0] DEAD_MAX_CYC = 16'h00c8,
	parameter logic [15:0] DEAD_START_CYC = 16'h0064
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rhw_pkg::rhw_sense_t sense_in,
	output rhw_pkg::rhw_drive_t drive,
	output logic overcurrent_level_one_fault,
	output logic ovp_fault
);
	localparam int NS = $bits(rhw_pkg::rhw_sense_t);
	localparam logic [15:0] BLANK = 16'(`RHW_BLANK_CYC);

	// three-stage synchroniser, change accepted when stages two and three agree
	logic [NS-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_sync
			always_comb begin
				flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
			end
		end
	endgenerate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			flt_q <= '0;
		end else if (clk_en) begin
			s1_q <= sense_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			flt_q <= flt_d;
		end
	end
	rhw_pkg::rhw_sense_t sn;
	assign sn = flt_q;

	// apb register file
	logic waveform_enable_q, waveform_enable_d;
	logic [15:0] on_min_q, on_min_d, on_max_q, on_max_d;
	logic [31:0] prdata_d, status_w, cycles_w;
	logic pready_d, pslverr_d, hit;
	rhw_pkg::rhw_state_t st_q, st_d;
	logic [15:0] cnt_q, cnt_d, swc_q, swc_d;
	logic [3:0] burst_q, burst_d, start_q, start_d;
	logic [2:0] ocp_q, ocp_d, ovp_q, ovp_d;
	logic ocp_seen_q, ocp_seen_d, ovp_prev_q, sign_prev_q, en_prev_q;
	logic enable_rise_seen_q, enable_rise_seen_d;
	logic overcurrent_level_one_fault_d, ovp_fault_d;
	rhw_pkg::rhw_drive_t drive_d;

	assign status_w = {13'h0, ovp_fault, overcurrent_level_one_fault, ovp_q, ocp_q, start_q, burst_q, st_q};
	assign cycles_w = {16'h0, swc_q};
	always_comb begin
		waveform_enable_d = waveform_enable_q;
		on_min_d = on_min_q;
		on_max_d = on_max_q;
		prdata_d = prdata;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		hit = 1'b1;
		if (psel && penable && !pready) begin
			pready_d = 1'b1;
			prdata_d = 32'h0;
			unique case (paddr)
				`RHW_ADDR_CTRL: begin
					prdata_d[`RHW_CTRL_EN_BIT] = waveform_enable_q;
					if (pwrite) waveform_enable_d = pwdata[`RHW_CTRL_EN_BIT];
				end
				`RHW_ADDR_ON_TIME: begin
					prdata_d = {on_max_q, on_min_q};
					if (pwrite) begin
						on_min_d = pwdata[15:0];
						on_max_d = pwdata[31:16];
					end
				end
				`RHW_ADDR_STATUS: prdata_d = status_w;
				`RHW_ADDR_CYCLES: prdata_d = cycles_w;
				default: hit = 1'b0;
			endcase
			pslverr_d = !hit;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			waveform_enable_q <= 1'b0;
			on_min_q <= `RHW_ON_MIN_RST;
			on_max_q <= `RHW_ON_MAX_RST;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			waveform_enable_q <= waveform_enable_d;
			on_min_q <= on_min_d;
			on_max_q <= on_max_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
		end
	end

	// waveform state machine, timers and cycle counters
	logic dead_st, blanked, sign_fall, ls_done, hs_done, dead_done, at_max, en_rise, blank_nx;
	always_comb begin
		dead_st = (st_q == rhw_pkg::ST_DEAD_LH) || (st_q == rhw_pkg::ST_DEAD_HL);
		en_rise = waveform_enable_q && !en_prev_q; // enable rising in this cycle
		blanked = dead_st && (cnt_q < BLANK); // R8
		sign_fall = sign_prev_q && !sn.resonant_current_sign && !blanked; // R8
		at_max = cnt_q >= on_max_q;
		ls_done = (cnt_q >= on_min_q) && (sn.cap_volt_below_low || at_max); // R19 R7
		hs_done = (cnt_q >= on_min_q) && (sn.cap_volt_above_high || at_max); // R20 R7
		dead_done = (cnt_q >= DEAD_MIN_CYC) && (sign_fall || cnt_q >= DEAD_MAX_CYC
			|| (start_q != 4'h0 && cnt_q >= DEAD_START_CYC)); // R7
		st_d = st_q;
		burst_d = burst_q;
		start_d = start_q;
		ocp_d = ocp_q;
		ovp_d = ovp_q;
		swc_d = swc_q;
		ocp_seen_d = ocp_seen_q || sn.overcurrent_level_one;
		enable_rise_seen_d = enable_rise_seen_q || en_rise;
		overcurrent_level_one_fault_d = 1'b0;
		ovp_fault_d = 1'b0;
		if (sn.bias_overvoltage && !ovp_prev_q && ovp_q != 3'h0) ovp_d = ovp_q - 3'h1; // R17
		unique case (st_q)
			rhw_pkg::ST_IDLE: begin
				if (enable_rise_seen_q || en_rise) begin // rise may leave idle at once
					start_d = `RHW_STARTUP_LOAD; // R10
					enable_rise_seen_d = 1'b0;
				end
				if (waveform_enable_q && !sn.feedback_below_burst && cnt_q >= IDLE_MIN_CYC)
					st_d = rhw_pkg::ST_WAKE; // R2 R18
			end
			rhw_pkg::ST_WAKE: if (cnt_q >= WAKE_CYC) st_d = rhw_pkg::ST_LOW_ON; // R3
			rhw_pkg::ST_LOW_ON: begin
				if (ls_done) begin
					if (ocp_q == 3'h0 || ovp_q == 3'h0) begin
						st_d = rhw_pkg::ST_IDLE; // R17
						overcurrent_level_one_fault_d = (ocp_q == 3'h0);
						ovp_fault_d = (ovp_q == 3'h0);
					end else st_d = rhw_pkg::ST_DEAD_LH; // R4
				end
			end
			rhw_pkg::ST_DEAD_LH: if (dead_done || sn.switch_node_rose)
				st_d = rhw_pkg::ST_HIGH_ON; // R5
			rhw_pkg::ST_HIGH_ON: begin
				if (burst_q == 4'h0 && sn.cap_volt_above_mid && sn.feedback_below_burst
					&& cnt_q >= on_min_q) st_d = rhw_pkg::ST_IDLE; // R21
				else if (hs_done) st_d = rhw_pkg::ST_DEAD_HL; // R6
			end
			rhw_pkg::ST_DEAD_HL: begin
				if (dead_done || sn.switch_node_fell) begin
					st_d = rhw_pkg::ST_LOW_ON; // R6 R1
					swc_d = swc_q + 16'h1;
					if (burst_q != 4'h0) burst_d = burst_q - 4'h1; // R21
					if (start_q != 4'h0) start_d = start_q - 4'h1;
					if (ocp_seen_q && ocp_q != 3'h0) ocp_d = ocp_q - 3'h1; // R17
					ocp_seen_d = sn.overcurrent_level_one;
				end
			end
		endcase
		if (!waveform_enable_q) st_d = rhw_pkg::ST_IDLE; // R2
		if (st_d == rhw_pkg::ST_IDLE && st_q != rhw_pkg::ST_IDLE) begin
			burst_d = `RHW_BURST_LOAD; // R10 R21
			swc_d = 16'h0;
			ocp_d = `RHW_OVERCURRENT_LEVEL_ONE_LOAD;
			ovp_d = `RHW_OVP_LOAD;
			ocp_seen_d = 1'b0;
		end
		cnt_d = (st_d != st_q) ? 16'h0 : ((cnt_q == 16'hffff) ? cnt_q : cnt_q + 16'h1); // R7
	end

	// outputs decoded from the next state so they line up with it
	always_comb begin
		blank_nx = (st_d == rhw_pkg::ST_DEAD_LH || st_d == rhw_pkg::ST_DEAD_HL)
			&& (cnt_d < BLANK); // R8 blanking of the state being entered
		drive_d = '0; // R9 R11
		unique case (st_d)
			rhw_pkg::ST_LOW_ON: begin
				drive_d.low_gate_on = 1'b1; // R12
				drive_d.low_ramp_source_on = 1'b1;
			end
			rhw_pkg::ST_DEAD_LH: drive_d.high_ramp_source_on = 1'b1; // R13
			rhw_pkg::ST_HIGH_ON: begin
				drive_d.high_gate_on = 1'b1; // R14 R22
				drive_d.high_ramp_source_on = 1'b1;
			end
			rhw_pkg::ST_DEAD_HL: drive_d.low_ramp_source_on = 1'b1; // R15
			default: ;
		endcase
		if (st_d == rhw_pkg::ST_LOW_ON || st_d == rhw_pkg::ST_DEAD_LH)
			drive_d.zero_current_flag = sn.resonant_current_sign && !blank_nx; // R16
		else if (st_d == rhw_pkg::ST_HIGH_ON || st_d == rhw_pkg::ST_DEAD_HL)
			drive_d.zero_current_flag = !sn.resonant_current_sign && !blank_nx; // R16
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= rhw_pkg::ST_IDLE; // R2
			cnt_q <= 16'h0;
			swc_q <= 16'h0;
			burst_q <= `RHW_BURST_LOAD;
			start_q <= 4'h0;
			ocp_q <= `RHW_OVERCURRENT_LEVEL_ONE_LOAD;
			ovp_q <= `RHW_OVP_LOAD;
			ocp_seen_q <= 1'b0;
			ovp_prev_q <= 1'b0;
			sign_prev_q <= 1'b0;
			en_prev_q <= 1'b0;
			enable_rise_seen_q <= 1'b0;
			drive <= '0;
			overcurrent_level_one_fault <= 1'b0;
			ovp_fault <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			swc_q <= swc_d;
			burst_q <= burst_d;
			start_q <= start_d;
			ocp_q <= ocp_d;
			ovp_q <= ovp_d;
			ocp_seen_q <= ocp_seen_d;
			ovp_prev_q <= sn.bias_overvoltage;
			sign_prev_q <= sn.resonant_current_sign;
			en_prev_q <= waveform_enable_q;
			enable_rise_seen_q <= enable_rise_seen_d;
			drive <= drive_d;
			overcurrent_level_one_fault <= overcurrent_level_one_fault_d;
			ovp_fault <= ovp_fault_d;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	gates_exclusive_a: assert property (!(drive.high_gate_on && drive.low_gate_on))
		else $error("both gates on"); // R22
	idle_quiet_a: assert property (st_q == rhw_pkg::ST_IDLE || st_q == rhw_pkg::ST_WAKE
		|-> drive == '0) else $error("outputs active in idle or wake"); // R9 R11
	low_next_a: assert property (st_q == rhw_pkg::ST_LOW_ON && st_d != st_q
		|-> st_d inside {rhw_pkg::ST_DEAD_LH, rhw_pkg::ST_IDLE})
		else $error("low on left to wrong state"); // R4
	low_min_a: assert property (st_q == rhw_pkg::ST_LOW_ON && st_d == rhw_pkg::ST_DEAD_LH
		|-> cnt_q >= on_min_q) else $error("low on left before min"); // R19
	high_min_a: assert property (st_q == rhw_pkg::ST_HIGH_ON && st_d == rhw_pkg::ST_DEAD_HL
		|-> cnt_q >= on_min_q) else $error("high on left before min"); // R20
	dead_lh_exit_a: assert property (st_q == rhw_pkg::ST_DEAD_LH && st_d != st_q
		|-> st_d inside {rhw_pkg::ST_HIGH_ON, rhw_pkg::ST_IDLE})
		else $error("dead low-high left to wrong state"); // R5
	dead_hl_exit_a: assert property (st_q == rhw_pkg::ST_DEAD_HL && st_d != st_q
		|-> st_d inside {rhw_pkg::ST_LOW_ON, rhw_pkg::ST_IDLE})
		else $error("dead high-low left to wrong state"); // R6
	wake_time_a: assert property (st_q == rhw_pkg::ST_WAKE && st_d == rhw_pkg::ST_LOW_ON
		|-> cnt_q >= WAKE_CYC) else $error("wake-up left early"); // R3
	burst_reload_a: assert property (clk_en && st_q != rhw_pkg::ST_IDLE
		&& st_d == rhw_pkg::ST_IDLE |=> burst_q == `RHW_BURST_LOAD && ocp_q == `RHW_OVERCURRENT_LEVEL_ONE_LOAD)
		else $error("counters not reloaded on idle entry"); // R10
	idle_exit_a: assert property (st_q == rhw_pkg::ST_IDLE && st_d == rhw_pkg::ST_WAKE
		|-> waveform_enable_q && !sn.feedback_below_burst && cnt_q >= IDLE_MIN_CYC)
		else $error("idle left without conditions"); // R18
	dead_gates_a: assert property (dead_st |-> !drive.high_gate_on && !drive.low_gate_on)
		else $error("gate on in dead time"); // R13 R15
endmodule : rhw_wavegen
`default_nettype wire

// ### design/rhw_defs.svh
`ifndef RHW_DEFS_SVH
`define RHW_DEFS_SVH
// clock and blanking time
`define RHW_CLK_PERIOD_PS 5000
`define RHW_BLANK_NS 1000
`define RHW_BLANK_CYC ((`RHW_BLANK_NS * 1000 + `RHW_CLK_PERIOD_PS - 1) / `RHW_CLK_PERIOD_PS)
// counter load values
`define RHW_BURST_LOAD 4'hf
`define RHW_STARTUP_LOAD 4'hf
`define RHW_OVERCURRENT_LEVEL_ONE_LOAD 3'h4
`define RHW_OVP_LOAD 3'h4
// register byte addresses
`define RHW_ADDR_CTRL 12'h000
`define RHW_ADDR_ON_TIME 12'h004
`define RHW_ADDR_STATUS 12'h008
`define RHW_ADDR_CYCLES 12'h00c
// field positions and reset values
`define RHW_CTRL_EN_BIT 0
`define RHW_ON_MIN_RST 16'h0064
`define RHW_ON_MAX_RST 16'h07d0
`endif

// ### design/rhw_pkg.sv
`default_nettype none
package rhw_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_WAKE, ST_LOW_ON, ST_DEAD_LH, ST_HIGH_ON, ST_DEAD_HL
	} rhw_state_t;
	// comparator and fault inputs from the analog side
	typedef struct packed {
		logic cap_volt_above_high;
		logic cap_volt_below_low;
		logic cap_volt_above_mid;
		logic switch_node_rose;
		logic switch_node_fell;
		logic resonant_current_sign;
		logic feedback_below_burst;
		logic overcurrent_level_one;
		logic bias_overvoltage;
	} rhw_sense_t;
	// gate and ramp drive outputs
	typedef struct packed {
		logic high_gate_on;
		logic low_gate_on;
		logic high_ramp_source_on;
		logic low_ramp_source_on;
		logic zero_current_flag;
	} rhw_drive_t;
endpackage : rhw_pkg
`default_nettype wire

// ### verif/rhw_partner.sv
`timescale 1ns/1ps
`default_nettype none
module rhw_partner (
	input wire logic pclk,
	input wire logic slow,
	input wire logic ovp_in,
	input wire rhw_pkg::rhw_drive_t drive,
	output rhw_pkg::rhw_sense_t sense
);
	logic [7:0] cnt_q = 8'h00;
	logic [3:0] last_q = 4'h0;
	logic hit;
	// cycles since the bridge last changed its drive pattern
	always_ff @(posedge pclk) begin
		last_q <= drive[4:1];
		cnt_q <= (drive[4:1] != last_q) ? 8'h00 : ((cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01);
	end
	// slow comparators trip after the on and dead timers run out
	assign hit = cnt_q >= (slow ? 8'h3c : 8'h06);
	// comparators trip a while after each edge, except the mid comparator, which follows the high gate at once
	always_comb begin
		sense = '0;
		sense.cap_volt_below_low = drive.low_gate_on && hit;
		sense.cap_volt_above_high = drive.high_gate_on && hit;
		sense.cap_volt_above_mid = drive.high_gate_on;
		sense.switch_node_rose = drive.high_ramp_source_on && !drive.high_gate_on && hit;
		sense.switch_node_fell = drive.low_ramp_source_on && !drive.low_gate_on && hit;
		sense.bias_overvoltage = ovp_in; // bias winding fault from the bench
	end
endmodule : rhw_partner
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic slow = 1'b0;
	logic clk_en = 1'b1;
	logic ovp_in = 1'b0;
	logic ovp_fault;
	int n_ovp = 0;
	rhw_pkg::rhw_sense_t sense;
	rhw_pkg::rhw_drive_t drive;
	logic [31:0] rd;
	logic er;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	int len;
	// 200 MHz clock
	always #2.5 pclk = ~pclk;
	rhw_wavegen #(.IDLE_MIN_CYC(16'h0008), .WAKE_CYC(16'h000a), .DEAD_MIN_CYC(16'h0004),
		.DEAD_MAX_CYC(16'h0014), .DEAD_START_CYC(16'h000c)) u_dut (.pclk(pclk),
		.presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sense_in(sense), .drive(drive), .overcurrent_level_one_fault(), .ovp_fault(ovp_fault));
	rhw_partner u_far (.pclk(pclk), .slow(slow), .ovp_in(ovp_in), .drive(drive),
		.sense(sense));
	task finish_test;
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// wait for the next drive pattern, length of the old one in len
	task nxt(input logic [3:0] exp, input string nm);
		logic [3:0] cur;
		cur = drive[4:1];
		len = 0;
		while (drive[4:1] === cur && len < 400) begin
			@(posedge pclk);
			#1;
			len++;
		end
		chk(nm, {28'h0, exp}, {28'h0, drive[4:1]});
	endtask : nxt
	// hang guard and gate overlap watch
	always @(posedge pclk) begin
		cyc++;
		if (ovp_fault === 1'b1) n_ovp++;
		if (drive.high_gate_on === 1'b1 && drive.low_gate_on === 1'b1) begin
			err_total++;
			$display("BAD gates exp 0 got 1");
		end
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	// main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		chk("drive", 32'h0, {27'h0, drive});
		apb(1'b0, 12'h008, 32'h0);
		chk("state", 32'h0, {29'h0, rd[2:0]});
		apb(1'b0, 12'h004, 32'h0);
		chk("on_time", 32'h07d00064, rd);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'b1, 12'h004, 32'h00280014);
		apb(1'b1, 12'h000, 32'h00000001);
		len = 0;
		do begin
			apb(1'b0, 12'h008, 32'h0);
			len++;
		end while (rd[2:0] !== 3'h1 && len < 50);
		chk("wake", 32'h1, {29'h0, rd[2:0]});
		chk("wake drive", 32'h0, {27'h0, drive});
		nxt(4'b0101, "low on");
		nxt(4'b0010, "dead lh");
		nxt(4'b1010, "high on");
		nxt(4'b0001, "dead hl");
		nxt(4'b0101, "low again");
		nxt(4'b0010, "dead lh");
		chk("low min", 32'h1, {31'h0, len >= 20 && len <= 24});
		slow <= 1'b1;
		nxt(4'b1010, "high on");
		// freeze 8 cycles: the on timer must resume where it stopped
		@(posedge pclk);
		clk_en <= 1'b0;
		repeat (8) @(posedge pclk);
		clk_en <= 1'b1;
		#1;
		chk("frozen", 32'h15, {27'h0, drive});
		nxt(4'b0001, "dead hl");
		chk("high max", 32'h1, {31'h0, len >= 40 && len <= 44});
		nxt(4'b0101, "low on");
		nxt(4'b0010, "dead lh");
		chk("low max", 32'h1, {31'h0, len >= 40 && len <= 44});
		// four bias overvoltage events empty the counter: one fault, back to idle
		repeat (4) begin
			@(posedge pclk);
			ovp_in <= 1'b1;
			repeat (4) @(posedge pclk);
			ovp_in <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		repeat (200) @(posedge pclk);
		chk("ovp fault", 32'h1, n_ovp);
		apb(1'b1, 12'h000, 32'h0);
		repeat (3) @(posedge pclk);
		#1;
		chk("off drive", 32'h0, {27'h0, drive});
		apb(1'b0, 12'h008, 32'h0);
		chk("off state", 32'h0, {29'h0, rd[2:0]});
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
